// file: rtl/jt_consts.svh
// Constants of the boundary-scan test port: instruction codes, register
// widths, capture and reset values, and the depth of the word buffer.
// Assumes inclusion by bare name from the package and the bench.
`ifndef JT_CONSTS_SVH
`define JT_CONSTS_SVH

// ******************************************************************
// Instruction register
// ******************************************************************
`define JT_IR_W 4
`define JT_IR_CAPTURE 4'h1
`define JT_INS_IDCODE 4'h1
`define JT_INS_USER 4'h8
`define JT_INS_BYPASS 4'hf

// ******************************************************************
// Data registers
// ******************************************************************
`define JT_ID_W 32
`define JT_IDCODE_DEF 32'h0000_0001
`define JT_USR_W 8
`define JT_USR_RST 8'h00

// ******************************************************************
// Word buffer towards the system clock
// ******************************************************************
`define JT_FIFO_D 32

`endif

// file: rtl/jt_pkg.sv
// Types shared by the test port and its word buffer.
// Assumes the constants header is on the include path.
`include "jt_consts.svh"

package jt_pkg;

   // Sixteen controller states of the test access port.
   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SDS, ST_CDR, ST_SDR, ST_E1D, ST_PDR, ST_E2D,
      ST_UDR, ST_SIS, ST_CIR, ST_SIR, ST_E1I, ST_PIR, ST_E2I, ST_UIR
   } jt_state_type;

   // One word handed from the scan side to the system side.
   typedef struct packed {
      logic lost;
      logic [`JT_USR_W-1:0] payload;
   } jt_word_type;

endpackage

// file: rtl/jt_sync.sv
// Two-flop synchroniser for levels and toggles, any width.
// Assumes each bit is an independent level or toggle.
`timescale 1ns/10ps

module jt_sync #(
   parameter int W = 1
) (
   // Destination clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Foreign-domain input and synchronised copy.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   // The first stage feeds only the second stage.
   always_comb
   begin
      s1_nxt = d;
      q_nxt = s1_r;
   end

   // Both stages clear to zero.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_r <= '0;
         q_r <= '0;
      end
      else
      begin
         s1_r <= s1_nxt;
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule // jt_sync

// file: rtl/jt_fifo.sv
// Word buffer with valid and ready on both sides and a registered output.
// Assumes D is a power of two; one clock for both sides.
`timescale 1ns/10ps

module jt_fifo #(
   parameter int W = 9,
   parameter int D = 32
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW+1)'(D);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic ov_r, ov_nxt;
   logic [W-1:0] od_r, od_nxt;
   logic push;
   logic load;

   // Output stage refills whenever it is empty or being taken.
   always_comb
   begin
      in_ready = (cnt_r != FULL);
      push = in_valid && in_ready;
      load = (cnt_r != '0) && (!ov_r || out_ready);
      wr_nxt = push ? wr_r + 1'b1 : wr_r;
      rd_nxt = load ? rd_r + 1'b1 : rd_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(load);
      ov_nxt = load ? 1'b1 : (out_ready ? 1'b0 : ov_r);
      od_nxt = load ? mem[rd_r] : od_r;
   end

   // Pointers, count and output register.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
         ov_r <= 1'b0;
         od_r <= '0;
      end
      else
      begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
         ov_r <= ov_nxt;
         od_r <= od_nxt;
      end
   end

   // Storage has no reset; only written words are ever read.
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_r] <= in_data;
      end
   end

   assign out_valid = ov_r;
   assign out_data = od_r;
endmodule // jt_fifo

// file: rtl/jt_tap.sv
// Boundary-scan test access port with a user data register whose updates
// are handed as words to the system clock through a buffer.
// Assumes the test controller drives tck, tms, tdi and trst_n, and the
// system side drains words with valid and ready on clk.
`timescale 1ns/10ps

module jt_tap
   import jt_pkg::*;
#(
   parameter logic [`JT_ID_W-1:0] IDCODE = `JT_IDCODE_DEF // Arbitrary value.
) (
   // System clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Test port.
   input wire logic tck,
   input wire logic trst_n,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // Word stream to the system.
   output logic word_valid,
   input wire logic word_ready,
   output jt_word_type word_data
);
   // ******************************************************************
   // Scan-side state
   // ******************************************************************
   jt_state_type state_r, state_nxt;
   logic [`JT_IR_W-1:0] ir_sr_r, ir_sr_nxt, ir_r, ir_nxt;
   logic byp_r, byp_nxt;
   logic [`JT_ID_W-1:0] idc_r, idc_nxt;
   logic [`JT_USR_W-1:0] usr_r, usr_nxt;
   jt_word_type hold_r, hold_nxt;
   logic req_r, req_nxt;
   logic lost_r, lost_nxt;
   logic tdo_r, tdo_nxt, oe_r, oe_nxt;
   logic ack_t, full_t, busy;
   // System-side state.
   logic ack_r, ack_nxt, req_c, pending, fifo_ready, full_r, full_nxt;

   // A word is still in flight until the system side toggles back.
   assign busy = req_r ^ ack_t;

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_TLR: state_nxt = tms ? ST_TLR : ST_RTI;
         ST_RTI: state_nxt = tms ? ST_SDS : ST_RTI;
         ST_SDS: state_nxt = tms ? ST_SIS : ST_CDR;
         ST_CDR: state_nxt = tms ? ST_E1D : ST_SDR;
         ST_SDR: state_nxt = tms ? ST_E1D : ST_SDR;
         ST_E1D: state_nxt = tms ? ST_UDR : ST_PDR;
         ST_PDR: state_nxt = tms ? ST_E2D : ST_PDR;
         ST_E2D: state_nxt = tms ? ST_UDR : ST_SDR;
         ST_UDR: state_nxt = tms ? ST_SDS : ST_RTI;
         ST_SIS: state_nxt = tms ? ST_TLR : ST_CIR;
         ST_CIR: state_nxt = tms ? ST_E1I : ST_SIR;
         ST_SIR: state_nxt = tms ? ST_E1I : ST_SIR;
         ST_E1I: state_nxt = tms ? ST_UIR : ST_PIR;
         ST_PIR: state_nxt = tms ? ST_E2I : ST_PIR;
         ST_E2I: state_nxt = tms ? ST_UIR : ST_SIR;
         ST_UIR: state_nxt = tms ? ST_SDS : ST_RTI;
      endcase
   end

   // Scan registers: capture, shift and update. Bypass is the fallback for
   // unknown instructions so the chain length stays defined.
   always_comb
   begin
      ir_sr_nxt = ir_sr_r;
      ir_nxt = ir_r;
      byp_nxt = byp_r;
      idc_nxt = idc_r;
      usr_nxt = usr_r;
      hold_nxt = hold_r;
      req_nxt = req_r;
      lost_nxt = lost_r;
      if (state_r == ST_TLR)
      begin
         ir_nxt = `JT_INS_IDCODE;
      end
      if (state_r == ST_CIR)
      begin
         ir_sr_nxt = `JT_IR_CAPTURE;
      end
      if (state_r == ST_SIR)
      begin
         ir_sr_nxt = {tdi, ir_sr_r[`JT_IR_W-1:1]};
      end
      if (state_r == ST_UIR)
      begin
         ir_nxt = ir_sr_r;
      end
      if (state_r == ST_CDR)
      begin
         byp_nxt = 1'b0;
         if (ir_r == `JT_INS_IDCODE)
         begin
            idc_nxt = IDCODE;
         end
         if (ir_r == `JT_INS_USER)
         begin
            usr_nxt = {{(`JT_USR_W-2){1'b0}}, busy, full_t};
         end
      end
      if (state_r == ST_SDR)
      begin
         byp_nxt = tdi;
         if (ir_r == `JT_INS_IDCODE)
         begin
            idc_nxt = {tdi, idc_r[`JT_ID_W-1:1]};
         end
         if (ir_r == `JT_INS_USER)
         begin
            usr_nxt = {tdi, usr_r[`JT_USR_W-1:1]};
         end
      end
      // An update while the previous word is in flight is dropped, and
      // the next word that gets through carries the lost mark.
      if (state_r == ST_UDR && ir_r == `JT_INS_USER)
      begin
         if (busy)
         begin
            lost_nxt = 1'b1;
         end
         else
         begin
            hold_nxt = '{lost: lost_r, payload: usr_r};
            req_nxt = ~req_r;
            lost_nxt = 1'b0;
         end
      end
   end

   // static state
   // Plain flip-flops with no refresh, so a stopped clock loses nothing.
   always_ff @(posedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         state_r <= ST_TLR;
         ir_sr_r <= '0;
         ir_r <= `JT_INS_IDCODE;
         byp_r <= 1'b0;
         idc_r <= '0;
         usr_r <= `JT_USR_RST;
         hold_r <= '0;
         req_r <= 1'b0;
         lost_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         ir_sr_r <= ir_sr_nxt;
         ir_r <= ir_nxt;
         byp_r <= byp_nxt;
         idc_r <= idc_nxt;
         usr_r <= usr_nxt;
         hold_r <= hold_nxt;
         req_r <= req_nxt;
         lost_r <= lost_nxt;
      end
   end

   // ******************************************************************
   // Serial output, falling edge
   // ******************************************************************
   // enable only in shift
   always_comb
   begin
      oe_nxt = (state_r == ST_SIR) || (state_r == ST_SDR);
      tdo_nxt = tdo_r;
      if (state_r == ST_SIR)
      begin
         tdo_nxt = ir_sr_r[0];
      end
      else if (state_r == ST_SDR)
      begin
         if (ir_r == `JT_INS_IDCODE)
         begin
            tdo_nxt = idc_r[0];
         end
         else if (ir_r == `JT_INS_USER)
         begin
            tdo_nxt = usr_r[0];
         end
         else
         begin
            tdo_nxt = byp_r;
         end
      end
   end

   always_ff @(negedge tck or negedge trst_n)
   begin
      if (!trst_n)
      begin
         tdo_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else
      begin
         tdo_r <= tdo_nxt;
         oe_r <= oe_nxt;
      end
   end

   assign tdo = tdo_r;
   assign tdo_oe = oe_r;

   // ******************************************************************
   // Crossing between test clock and system clock
   // ******************************************************************
   // Toggle request into the system domain.
   jt_sync #(.W(1)) u_req_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d(req_r),
      .q(req_c)
   );

   // Acknowledge toggle and buffer-full level into the scan domain.
   jt_sync #(.W(2)) u_ack_sync (
      .clk(tck),
      .arst_n(trst_n),
      .d({ack_r, full_r}),
      .q({ack_t, full_t})
   );

   // The held word is stable while a request is pending, so the system
   // side may read it directly. A full buffer stalls the acknowledge.
   // The full level is registered so that no compare glitch reaches the
   // synchroniser.
   always_comb
   begin
      pending = req_c ^ ack_r;
      ack_nxt = (pending && fifo_ready) ? ~ack_r : ack_r;
      full_nxt = ~fifo_ready;
   end

   // Acknowledge toggle and full level, both on the system clock.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ack_r <= 1'b0;
         full_r <= 1'b0;
      end
      else
      begin
         ack_r <= ack_nxt;
         full_r <= full_nxt;
      end
   end

   jt_fifo #(.W($bits(jt_word_type)), .D(`JT_FIFO_D)) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(pending),
      .in_ready(fifo_ready),
      .in_data(hold_r),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(word_data)
   );

   // ******************************************************************
   // Checks
   // ******************************************************************
   property p_trst_clears;
      @(posedge tck) !trst_n |-> (state_r == ST_TLR && !oe_r);
   endproperty
   a_trst_clears: assert property (p_trst_clears) else $error("test reset did not clear port");

   property p_tms_five_high;
      @(posedge tck) disable iff (!trst_n) tms [*5] |=> state_r == ST_TLR;
   endproperty
   a_tms_five_high: assert property (p_tms_five_high) else $error("five high tms not in reset");

   property p_bypass_shift;
      @(posedge tck) disable iff (!trst_n)
         (state_r == ST_SDR && ir_r == `JT_INS_BYPASS) |=> byp_r == $past(tdi);
   endproperty
   a_bypass_shift: assert property (p_bypass_shift) else $error("bypass missed tdi");

   property p_tdo_fall;
      @(negedge tck) disable iff (!trst_n)
         (state_r == ST_SIR) |=> tdo == $past(ir_sr_r[0]);
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo not set on falling edge");

   property p_oe_idle;
      @(negedge tck) disable iff (!trst_n)
         !(state_r == ST_SIR || state_r == ST_SDR) |=> !tdo_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("tdo driven outside shift");

   property p_capture_to_shift;
      @(posedge tck) disable iff (!trst_n)
         (state_r == ST_CDR && !tms) ##1 (state_r == ST_SDR && tms) |=> state_r == ST_E1D;
   endproperty
   a_capture_to_shift: assert property (p_capture_to_shift) else $error("dr path wrong");

   property p_update_next;
      @(posedge tck) disable iff (!trst_n)
         (state_r == ST_UIR && tms) |=> state_r == ST_SDS ##1
            state_r == ($past(tms) ? ST_SIS : ST_CDR);
   endproperty
   a_update_next: assert property (p_update_next) else $error("update exit wrong");

   property p_word_held;
      @(posedge clk) disable iff (!arst_n)
         (pending && !fifo_ready) |=> (pending && $stable(hold_r));
   endproperty
   a_word_held: assert property (p_word_held) else $error("stalled word lost");
endmodule // jt_tap

// file: tb/jt_ctl_model.sv
// Model of the external test controller that drives the scan port.
// Assumes the bench resolves the serial output pin and calls its tasks.
`timescale 1ns/10ps

module jt_ctl_model (
   // Lines driven by the controller.
   output logic tck,
   output logic trst_n,
   output logic tms,
   output logic tdi,
   // Resolved serial output pin.
   input wire logic tdo_pin
);
   // Clock stands low and the pulled-up lines idle high outside frames.
   initial
   begin
      tck = 1'b0;
      trst_n = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // stable at rise
   // One 30 ns period; lines move just after the fall, never near the rise.
   task automatic tick(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #14;
      o = tdo_pin;
      tck = 1'b1;
      #15;
      tck = 1'b0;
      #1;
   endtask

   // mode high at release
   // Test reset pulse with one clock edge inside it, then one edge to reach
   // the idle state.
   task automatic reset_port(input int low_ns);
      logic o;
      tms = 1'b1;
      trst_n = 1'b0;
      #(low_ns);
      tick(1'b1, 1'b1, o);
      trst_n = 1'b1;
      #10;
      tick(1'b0, 1'b1, o);
   endtask

   // Scan of n bits from idle back to idle; a stall mid-shift is the slow case.
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
      input int stall, output logic [31:0] dout);
      logic o;
      dout = '0;
      tick(1'b1, 1'b1, o);
      if (ir)
         tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
      tick(1'b0, 1'b1, o);
      for (int i = 0; i < n; i++)
      begin
         if (i == n / 2)
            #(stall);
         tick(i == n - 1, din[i], o);
         dout[i] = o;
      end
      tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
      tick(1'b0, 1'b1, o);
      tms = 1'b1;
      tdi = 1'b1;
   endtask
endmodule // jt_ctl_model

// file: tb/tb_top.sv
// Self-checking bench of the scan port and its word stream.
// Assumes the design files and the controller model are compiled first.
`timescale 1ns/10ps
`include "jt_consts.svh"

module tb_top;
   import jt_pkg::*;

   typedef struct {
      logic [3:0] ins;
      int n;
      logic [31:0] din;
      int stall;
      logic [31:0] exp;
   } jt_row_type;

   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic word_ready = 1'b0;
   wire logic tck, trst_n, tms, tdi, tdo_pin;
   logic tdo, tdo_oe, word_valid;
   // Mode select walk through update-IR with mode high, then four highs.
   localparam logic [11:0] TMS_WALK = 12'h7f3;
   jt_word_type word_data, w;
   logic [31:0] d;
   jt_row_type rows [7];
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc = 0;

   // The pin floats whenever the port does not drive it.
   assign tdo_pin = tdo_oe ? tdo : 1'bz;

   jt_tap i_dut (.clk(clk), .arst_n(arst_n), .tck(tck), .trst_n(trst_n),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .word_valid(word_valid),
      .word_ready(word_ready), .word_data(word_data));
   jt_ctl_model i_ctl (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
      .tdo_pin(tdo_pin));

   // System clock of 50 ns.
   always #25 clk = ~clk;

   // ******************************************************************
   // Checking and closing
   // ******************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // A hang costs a mismatch; the whole run needs about a thousand cycles.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   always @(tdo) chk(tck, 1'b0);

   // ******************************************************************
   // Stream helpers
   // ******************************************************************
   task automatic set_ready(input logic v);
      @(posedge clk);
      #2;
      word_ready = v;
   endtask

   // Bounded wait for an offered word, taken at the next edge.
   task automatic get_word(output jt_word_type wd);
      int k;
      k = 0;
      while (word_valid !== 1'b1 && k < 40)
      begin
         @(posedge clk);
         #2;
         k++;
      end
      chk(word_valid, 1'b1);
      wd = word_data;
      @(posedge clk);
      #2;
   endtask

   // ******************************************************************
   // Main sequence
   // ******************************************************************
   initial
   begin
      rows = '{'{`JT_INS_IDCODE, `JT_ID_W, 32'h0, 5000, `JT_IDCODE_DEF},
         '{`JT_INS_BYPASS, 4, 32'hb, 0, 32'h6}, '{4'h3, 4, 32'h9, 0, 32'h2},
         '{`JT_INS_USER, `JT_USR_W, 32'ha5, 0, 32'h0},
         '{`JT_INS_USER, `JT_USR_W, 32'h5a, 0, 32'h0},
         '{`JT_INS_USER, `JT_USR_W, 32'h00, 0, 32'h0},
         '{`JT_INS_USER, `JT_USR_W, 32'hff, 0, 32'h0}};
      repeat (20) @(posedge clk);
      #2;
      arst_n = 1'b1;
      i_ctl.reset_port(100);
      // Ordinary cases: instruction, data scan, and a word for user writes.
      foreach (rows[r])
      begin
         i_ctl.scan(1'b1, `JT_IR_W, {28'h0, rows[r].ins}, 0, d);
         chk(d, {28'h0, `JT_IR_CAPTURE});
         set_ready(rows[r].ins == `JT_INS_USER);
         i_ctl.scan(1'b0, rows[r].n, rows[r].din, rows[r].stall, d);
         chk(d, rows[r].exp);
         chk(tdo_oe, 1'b0);
         if (word_ready)
         begin
            get_word(w);
            chk(w, {1'b0, rows[r].din[7:0]});
         end
         set_ready(1'b0);
      end
      // Test reset in mid-shift acts with the clock stopped.
      for (int i = 0; i < 3; i++)
         i_ctl.tick(i == 0, 1'b0, d[0]);
      chk(tdo_oe, 1'b1);
      fork
         i_ctl.reset_port(200);
         #100 chk(tdo_oe, 1'b0);
      join
      // A one-bit scan goes from capture through a single shift bit to exit.
      i_ctl.scan(1'b0, 1, 32'h0, 0, d);
      chk(d, 32'h1 & `JT_IDCODE_DEF);
      i_ctl.scan(1'b0, `JT_ID_W, 32'h0, 0, d);
      chk(d, `JT_IDCODE_DEF);
      // Five high mode edges always return to reset from any state.
      i_ctl.scan(1'b1, `JT_IR_W, {28'h0, `JT_INS_BYPASS}, 0, d);
      for (int i = 0; i < 12; i++)
         i_ctl.tick(TMS_WALK[i], 1'b1, d[0]);
      i_ctl.scan(1'b0, `JT_ID_W, 32'h0, 0, d);
      chk(d, `JT_IDCODE_DEF);
      // Fill the buffer with the stream stalled until updates are dropped.
      i_ctl.scan(1'b1, `JT_IR_W, {28'h0, `JT_INS_USER}, 0, d);
      for (int i = 0; i < 35; i++)
      begin
         i_ctl.scan(1'b0, `JT_USR_W, i, 0, d);
         chk(d, (i == 33) ? 32'h1 : (i == 34) ? 32'h3 : 32'h0);
         repeat (10) @(posedge clk);
      end
      #2;
      word_ready = 1'b1;
      for (int j = 0; j < 34; j++)
      begin
         get_word(w);
         chk(w.payload, j);
         chk(w.lost, 1'b0);
      end
      chk(word_valid, 1'b0);
      i_ctl.scan(1'b0, `JT_USR_W, 32'h5c, 0, d);
      get_word(w);
      chk({w.lost, w.payload}, 32'h15c);
      set_ready(1'b0);
      finish_test();
   end
endmodule // tb_top
